/* File: dp_master.sv */
// fieldbus master model: link state and the output image it sends
// assumes the bench steers it on mclk and gives the station address
`timescale 1ns/100ps
module dp_master #(
  parameter int NS = 4
) (
  input wire logic mclk,
  input wire logic run,
  input wire logic halt,
  input wire logic load,
  input wire logic [6:0] sta,
  input wire logic [NS*8-1:0] dimg,
  input wire logic [NS*16-1:0] wimg,
  output logic link_ok = 1'b0,
  output logic master_stopped = 1'b0,
  output logic [NS*8-1:0] dout_cmd = '0,
  output logic [NS*16-1:0] wout_cmd = '0
);
  // exchange runs only with a station in the valid range
  always @(posedge mclk) begin
    link_ok <= run && sta >= 7'h01 && sta <= 7'h70;
    master_stopped <= halt;
  end
  // a new output image replaces the old one only when sent
  always @(posedge mclk) begin
    if (load) begin
      dout_cmd <= dimg;
      wout_cmd <= wimg;
    end
  end
endmodule

/* File: rio_addr_disp.sv */
// station address sequencer: three decimal digits, then a long pause
// assumes a synchronous active-low reset and a stable address
`timescale 1ns/100ps
`include "rio_defs.svh"
module rio_addr_disp #(
  parameter int unsigned DIGIT_CYC =
    `RIO_DIGIT_MS * (`RIO_MS_NS / `RIO_CLK_NS),
  parameter int unsigned SHORT_CYC =
    `RIO_SHORT_MS * (`RIO_MS_NS / `RIO_CLK_NS),
  parameter int unsigned LONG_CYC =
    `RIO_LONG_MS * (`RIO_MS_NS / `RIO_CLK_NS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [6:0] addr,
  output logic [3:0] digit,
  output logic blank
);
  import rio_pkg::*;

  disp_state_t st_q, st_d; // sequencer state
  logic [31:0] cnt_q, cnt_d; // cycles left in this phase
  logic [1:0] idx_q, idx_d; // digit index, hundreds first
  logic [3:0] digit_q;
  logic blank_q;

  // pick one decimal digit of the address
  function automatic logic [3:0] digit_of(input logic [6:0] a,
                                          input logic [1:0] i);
    logic [6:0] v;
    v = 7'h00;
    if (i == 2'd0) begin
      v = a / 7'd100;
    end else if (i == 2'd1) begin
      v = (a / 7'd10) % 7'd10;
    end else begin
      v = a % 7'd10;
    end
    return v[3:0];
  endfunction

  // phase walk: digit, short gap, ..., last digit, long gap
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q - 32'h0000_0001;
    idx_d = idx_q;
    case (st_q)
      DSP_SHOW: begin
        if (cnt_q == 32'h0000_0000) begin
          if (idx_q == 2'd2) begin
            st_d = DSP_LONG;
            cnt_d = 32'(LONG_CYC - 1);
          end else begin
            st_d = DSP_GAP;
            cnt_d = 32'(SHORT_CYC - 1);
          end
        end
      end
      DSP_GAP: begin
        if (cnt_q == 32'h0000_0000) begin
          st_d = DSP_SHOW;
          idx_d = idx_q + 2'd1;
          cnt_d = 32'(DIGIT_CYC - 1);
        end
      end
      default: begin
        if (cnt_q == 32'h0000_0000) begin
          st_d = DSP_SHOW; // repeat from the first digit
          idx_d = 2'd0;
          cnt_d = 32'(DIGIT_CYC - 1);
        end
      end
    endcase
  end

  // state and registered display outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= DSP_SHOW;
      cnt_q <= 32'(DIGIT_CYC - 1);
      idx_q <= 2'd0;
      digit_q <= 4'h0;
      blank_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      digit_q <= digit_of(addr, idx_d);
      blank_q <= (st_d != DSP_SHOW);
    end
  end

  assign digit = digit_q;
  assign blank = blank_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // the last digit is followed by the long pause
  property p_last_long;
    (st_q == DSP_SHOW && idx_q == 2'd2 && cnt_q == 32'h0000_0000)
      |=> (st_q == DSP_LONG && blank_q);
  endproperty
  a_last_long: assert property (p_last_long)
    else $error("long pause missing after last digit");

  // the long pause starts with more cycles than a short pause has
  property p_gap_short;
    $rose(st_q == DSP_LONG) |-> (cnt_q >= 32'(SHORT_CYC));
  endproperty
  a_gap_short: assert property (p_gap_short)
    else $error("long pause not longer than short pause");
endmodule

/* File: rio_base_ctrl.sv */
// status display, output fallback and update scheduling of a remote base
// assumes a 125 mhz mclk, axi4-lite software access, synchronous inputs
`timescale 1ns/100ps
`include "rio_defs.svh"
module rio_base_ctrl #(
  parameter int unsigned NS = 4,
  parameter int unsigned MS_CYC = `RIO_MS_NS / `RIO_CLK_NS,
  parameter int unsigned DIGIT_CYC = `RIO_DIGIT_MS * MS_CYC,
  parameter int unsigned SHORT_CYC = `RIO_SHORT_MS * MS_CYC,
  parameter int unsigned LONG_CYC = `RIO_LONG_MS * MS_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // option switches and jumper
  input wire logic [6:0] station_addr_switch,
  input wire logic display_select_switch,
  input wire logic output_fallback_jumper_present,
  input wire logic output_fallback_jumper_freeze,
  // link and health status
  input wire logic link_ok,
  input wire logic master_stopped,
  input wire logic diag_fail,
  input wire rio_pkg::diag_kind_t diag_kind,
  // base configuration check per slot
  input wire logic [NS-1:0] slot_match,
  input wire logic [NS-1:0] slot_wrong,
  input wire logic [NS-1:0] word_zero_select,
  // i/o data
  input wire logic [NS*`RIO_DBITS-1:0] dout_cmd,
  input wire logic [NS*`RIO_WBITS-1:0] wout_cmd,
  input wire logic [NS*`RIO_DBITS-1:0] din_field,
  output logic [NS*`RIO_DBITS-1:0] dout,
  output logic [NS*`RIO_WBITS-1:0] wout,
  output logic [NS*`RIO_DBITS-1:0] din_report,
  output rio_pkg::disp_char_t disp_char,
  output logic disp_dp,
  output logic offline
);
  import rio_pkg::*;

  localparam int DB = `RIO_DBITS;
  localparam int WB = `RIO_WBITS;

  // reset release synchroniser
  logic rst_meta_n_q, rst_n_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_n_q <= 1'b1;
      rst_n_q <= rst_meta_n_q;
    end
  end

  // option switches, caught once after reset release
  logic sampled_q; // set after the one capture
  logic [6:0] addr_q; // station address
  logic disp_sel_q; // display select switch
  logic freeze_q; // effective fallback position
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sampled_q <= 1'b0;
      addr_q <= 7'h00;
      disp_sel_q <= 1'b0;
      freeze_q <= 1'b0;
    end else if (!sampled_q) begin
      sampled_q <= 1'b1;
      addr_q <= station_addr_switch;
      disp_sel_q <= display_select_switch;
      // absent jumper reads as off
      freeze_q <= output_fallback_jumper_present &
                  output_fallback_jumper_freeze;
    end
  end

  // software registers
  logic tol_q; // mismatch tolerance
  logic [7:0] ivl_q; // discrete interval, ms
  logic [7:0] fac_q; // word update factor
  logic [4:0] code_q; // last status code
  logic offline_q;

  // write channel holding
  logic aw_full_q, w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_full_q | aw_take;
  wire w_have = w_full_q | w_take;
  wire wr_do = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
  wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_q;
  wire wr_strb0 = w_take ? s_axi_wstrb[0] : wstrb0_q;
  wire aw_full_d = aw_have & ~wr_do;
  wire w_full_d = w_have & ~wr_do;
  wire bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);

  // write decode
  wire wr_ctrl = wr_addr == `RIO_OFF_CTRL;
  wire wr_ivl = wr_addr == `RIO_OFF_IVL;
  wire wr_fac = wr_addr == `RIO_OFF_FAC;
  wire wr_stat = wr_addr == `RIO_OFF_STAT;
  wire wr_known = wr_ctrl | wr_ivl | wr_fac | wr_stat;
  wire wr_en = wr_do & wr_strb0;
  // zero is outside the valid range and is ignored
  wire ivl_ok = wr_data[7:0] != 8'h00;

  // write channel handshake and response
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RIO_RESP_OK;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~aw_full_d & ~bvalid_d;
      s_axi_wready <= ~w_full_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_do) begin
        s_axi_bresp <= wr_known ? `RIO_RESP_OK : `RIO_RESP_ERR;
      end
    end
  end

  // register updates from software
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tol_q <= `RIO_TOL_RST;
      ivl_q <= `RIO_IVL_RST;
      fac_q <= `RIO_FAC_RST;
    end else if (wr_en) begin
      if (wr_ctrl) begin
        tol_q <= wr_data[`RIO_CTRL_TOL];
      end else if (wr_ivl && ivl_ok) begin
        ivl_q <= wr_data[7:0];
      end else if (wr_fac && ivl_ok) begin
        fac_q <= wr_data[7:0];
      end
    end
  end

  // read path
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire rd_ctrl = s_axi_araddr == `RIO_OFF_CTRL;
  wire rd_ivl = s_axi_araddr == `RIO_OFF_IVL;
  wire rd_fac = s_axi_araddr == `RIO_OFF_FAC;
  wire rd_stat = s_axi_araddr == `RIO_OFF_STAT;
  wire rd_known = rd_ctrl | rd_ivl | rd_fac | rd_stat;
  wire [31:0] stat_word = {18'h0_0000, disp_sel_q, addr_q,
                           offline_q, code_q};
  wire [31:0] rd_word = rd_ctrl ? {31'h0000_0000, tol_q} :
                        rd_ivl ? {24'h00_0000, ivl_q} :
                        rd_fac ? {24'h00_0000, fac_q} :
                        rd_stat ? stat_word : 32'h0000_0000;

  // read channel handshake and data
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RIO_RESP_OK;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? `RIO_RESP_OK : `RIO_RESP_ERR;
      end
    end
  end

  // update timing: millisecond tick, interval and word factor
  logic [31:0] ms_cnt_q;
  logic [7:0] ivl_cnt_q, fac_cnt_q;
  wire ms_tick = ms_cnt_q == 32'(MS_CYC - 1);
  wire ivl_hit = ivl_cnt_q >= ivl_q - 8'h01;
  wire fac_hit = fac_cnt_q >= fac_q - 8'h01;
  wire disc_stb = ms_tick & ivl_hit;
  wire word_stb = disc_stb & fac_hit;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ms_cnt_q <= 32'h0000_0000;
      ivl_cnt_q <= 8'h00;
      fac_cnt_q <= 8'h00;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (ms_tick) begin
        ivl_cnt_q <= ivl_hit ? 8'h00 : ivl_cnt_q + 8'h01;
      end
      if (disc_stb) begin
        fac_cnt_q <= fac_hit ? 8'h00 : fac_cnt_q + 8'h01;
      end
    end
  end

  // base state decode
  wire all_match = &slot_match;
  wire any_wrong = |slot_wrong;
  wire no_link = ~link_ok | master_stopped;
  // faults, link loss and untolerated mismatch take the base offline
  wire offline_w = no_link | diag_fail |
                   (~all_match & ~tol_q);
  // per-slot permission to exchange data
  wire [NS-1:0] upd_en = tol_q ? slot_match :
                         {NS{all_match}};
  wire [4:0] diag_char = (diag_kind == DIAG_UA) ? `RIO_CH_UA :
                         (diag_kind == DIAG_E) ? `RIO_CH_E : `RIO_CH_1;
  wire [4:0] code_w = diag_fail ? diag_char :
                      no_link ? `RIO_CH_3 :
                      (any_wrong & ~tol_q) ? `RIO_CH_LA :
                      ~all_match ? `RIO_CH_2 :
                      `RIO_CH_0;

  // data paths with fallback handling
  logic [NS*DB-1:0] dout_q, dout_d, din_q, din_d;
  logic [NS*WB-1:0] wout_q, wout_d;
  always_comb begin
    dout_d = dout_q;
    wout_d = wout_q;
    din_d = din_q;
    for (int i = 0; i < NS; i++) begin
      if (offline_w) begin
        // discrete: jumper alone decides
        if (!freeze_q) begin
          dout_d[i*DB +: DB] = '0;
        end
        // word: zero only for off position with zero select
        if (!freeze_q && word_zero_select[i]) begin
          wout_d[i*WB +: WB] = '0;
        end
      end else begin
        if (disc_stb && upd_en[i]) begin
          dout_d[i*DB +: DB] = dout_cmd[i*DB +: DB];
        end
        if (word_stb && upd_en[i]) begin
          wout_d[i*WB +: WB] = wout_cmd[i*WB +: WB];
        end
      end
      if (master_stopped) begin
        din_d[i*DB +: DB] = '0;
      end else if (disc_stb && upd_en[i] && !offline_w) begin
        din_d[i*DB +: DB] = din_field[i*DB +: DB];
      end
    end
  end

  // address sequencer for the address display mode
  logic [3:0] adr_digit;
  logic adr_blank;
  rio_addr_disp #(
    .DIGIT_CYC(DIGIT_CYC),
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_addr_disp (
    .mclk(mclk),
    .rst_n(sampled_q), // held until the address has been read
    .addr(addr_q),
    .digit(adr_digit),
    .blank(adr_blank)
  );
  wire [4:0] adr_char = adr_blank ? `RIO_CH_BLANK :
                        {1'b0, adr_digit};

  // registered outputs
  disp_char_t disp_q;
  logic dp_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dout_q <= '0;
      wout_q <= '0;
      din_q <= '0;
      code_q <= `RIO_CH_3;
      offline_q <= 1'b1;
      disp_q <= `RIO_CH_BLANK;
      dp_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      wout_q <= wout_d;
      din_q <= din_d;
      code_q <= code_w;
      offline_q <= offline_w;
      if (!sampled_q) begin
        disp_q <= `RIO_CH_BLANK; // switches not read yet
      end else begin
        disp_q <= disp_sel_q ? adr_char : code_w;
      end
      dp_q <= ~disp_sel_q & tol_q;
    end
  end

  assign dout = dout_q;
  assign wout = wout_q;
  assign din_report = din_q;
  assign disp_char = disp_q;
  assign disp_dp = dp_q;
  assign offline = offline_q;

  // helper: cycles since the last discrete update
  logic [31:0] gap_q;
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gap_q <= 32'h0000_0000;
    end else begin
      gap_q <= disc_stb ? 32'h0000_0000 : gap_q + 32'h0000_0001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n_q);

  sequence s_status_mode;
    sampled_q && !disp_sel_q;
  endsequence

  property p_code3;
    s_status_mode and (!diag_fail && !link_ok)
      |=> (disp_char == `RIO_CH_3);
  endproperty
  a_code3: assert property (p_code3)
    else $error("code 3 not shown on link loss");

  property p_code0;
    s_status_mode and (link_ok && !master_stopped && !diag_fail
                       && all_match)
      |=> (disp_char == `RIO_CH_0 && !offline);
  endproperty
  a_code0: assert property (p_code0)
    else $error("code 0 not shown when healthy");

  property p_dp;
    s_status_mode |=> (disp_dp == $past(tol_q));
  endproperty
  a_dp: assert property (p_dp)
    else $error("decimal point does not follow tolerance");

  property p_sample;
    sampled_q |=> $stable(addr_q) && $stable(freeze_q);
  endproperty
  a_sample: assert property (p_sample)
    else $error("option switches changed after startup");

  property p_off;
    (offline_w && !freeze_q) |=> (dout == '0);
  endproperty
  a_off: assert property (p_off)
    else $error("discrete outputs not off on fallback");

  property p_freeze;
    (offline_w && freeze_q) |=> $stable(dout);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("discrete outputs not frozen on fallback");

  property p_analog;
    (offline_w && (freeze_q || !word_zero_select[0]))
      |=> $stable(wout[WB-1:0]);
  endproperty
  a_analog: assert property (p_analog)
    else $error("word output not held on fallback");

  property p_noupd;
    (!tol_q && !all_match && !master_stopped) |=> $stable(din_report);
  endproperty
  a_noupd: assert property (p_noupd)
    else $error("update during untolerated mismatch");

  property p_tol;
    (tol_q && disc_stb && slot_match[0] && !offline_w
     && !master_stopped) |=> (din_report[DB-1:0] == $past(din_field[DB-1:0]));
  endproperty
  a_tol: assert property (p_tol)
    else $error("matching slot skipped under tolerance");

  property p_stop;
    master_stopped |=> (din_report == '0) && offline;
  endproperty
  a_stop: assert property (p_stop)
    else $error("inputs not cleared on master stop");

  property p_ivl;
    disc_stb |-> (gap_q >= 32'(ivl_q) * 32'(MS_CYC) - 32'h0000_0001);
  endproperty
  a_ivl: assert property (p_ivl)
    else $error("discrete updates too close together");
endmodule

/* File: rio_defs.svh */
// shared constants for the remote i/o base status and control block
// assumes a 125 mhz system clock and 32-bit axi4-lite register access
`ifndef RIO_DEFS_SVH
`define RIO_DEFS_SVH
// clock period and time units
`define RIO_CLK_NS 8
`define RIO_MS_NS 1000000
// address display timing in milliseconds
`define RIO_DIGIT_MS 500
`define RIO_SHORT_MS 250
`define RIO_LONG_MS 1000
// register byte offsets
`define RIO_OFF_CTRL 8'h00
`define RIO_OFF_IVL 8'h04
`define RIO_OFF_FAC 8'h08
`define RIO_OFF_STAT 8'h0C
// field positions and reset values
`define RIO_CTRL_TOL 0
`define RIO_TOL_RST 1'b0
`define RIO_IVL_RST 8'h01
`define RIO_FAC_RST 8'h02
// bus responses
`define RIO_RESP_OK 2'b00
`define RIO_RESP_ERR 2'b10
// display character codes
`define RIO_CH_0 5'h00
`define RIO_CH_1 5'h01
`define RIO_CH_2 5'h02
`define RIO_CH_3 5'h03
`define RIO_CH_UA 5'h0A
`define RIO_CH_LA 5'h0B
`define RIO_CH_E 5'h0E
`define RIO_CH_BLANK 5'h1F
// per-slot data widths
`define RIO_DBITS 8
`define RIO_WBITS 16
`endif

/* File: rio_pkg.sv */
// types shared by the status and control block and its display sequencer
// assumes rio_defs.svh holds all numeric constants
package rio_pkg;
  // address display sequencer states
  typedef enum logic [1:0] {
    DSP_SHOW = 2'b00,
    DSP_GAP = 2'b01,
    DSP_LONG = 2'b10
  } disp_state_t;
  // which failure character a diagnostic fault shows
  typedef enum logic [1:0] {
    DIAG_1 = 2'b00,
    DIAG_UA = 2'b01,
    DIAG_E = 2'b10
  } diag_kind_t;
  // display character code
  typedef logic [4:0] disp_char_t;
endpackage

/* File: tb.sv */
// self-checking bench of the remote base status and control block
// assumes the package, defines and master model compile before it
`timescale 1ns/100ps
module tb;
  import rio_pkg::*;
  localparam int NS = 4;
  logic mclk = 0;
  logic reset_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] station_addr_switch = 7'h69;
  logic display_select_switch = 0, run = 0, halt = 0, load = 0;
  logic output_fallback_jumper_present = 0;
  logic output_fallback_jumper_freeze = 0;
  logic link_ok, master_stopped, diag_fail = 0, disp_dp, offline;
  diag_kind_t diag_kind = DIAG_1;
  logic [NS-1:0] slot_match = '1, slot_wrong = '0, word_zero_select = '0;
  logic [NS*8-1:0] dout_cmd, dimg = '0, din_field = '0, dout, din_report;
  logic [NS*16-1:0] wout_cmd, wimg = '0, wout;
  disp_char_t disp_char;
  logic [1:0] bresp_seen = 2'b11;
  int seed = 32'h77a0, n_fail = 0, samples_checked = 0;
  initial forever #4 mclk = ~mclk;
  dp_master #(.NS(NS)) master (.mclk, .run, .halt, .load,
    .sta(station_addr_switch), .dimg, .wimg, .link_ok, .master_stopped,
    .dout_cmd, .wout_cmd);
  rio_base_ctrl #(.NS(NS), .MS_CYC(10), .DIGIT_CYC(20), .SHORT_CYC(10),
    .LONG_CYC(40)) dut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .station_addr_switch,
    .display_select_switch, .output_fallback_jumper_present,
    .output_fallback_jumper_freeze, .link_ok, .master_stopped, .diag_fail,
    .diag_kind, .slot_match, .slot_wrong, .word_zero_select, .dout_cmd,
    .wout_cmd, .din_field, .dout, .wout, .din_report, .disp_char, .disp_dp,
    .offline);
  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected status character from the present conditions
  function automatic int code(input bit t);
    if (diag_fail)
      return diag_kind == DIAG_UA ? 10 : diag_kind == DIAG_E ? 14 : 1;
    if (!run || halt)
      return 3;
    if (slot_wrong != 0 && !t)
      return 11;
    return slot_match != '1 ? 2 : 0;
  endfunction
  task automatic st(input bit t);
    int c = code(t);
    chk(disp_char, c);
    chk(offline, c % 2 == 1 || c > 9 || (slot_match != '1 && !t));
    chk(disp_dp, t);
  endtask
  task automatic rst(input bit s, input bit p, input bit f);
    reset_n <= 0;
    display_select_switch <= s;
    output_fallback_jumper_present <= p;
    output_fallback_jumper_freeze <= f;
    cyc(5);
    reset_n <= 1;
    cyc(6);
  endtask
  // one write: address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ta = 0, tw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (s_axi_awready && !ta) begin
        ta = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !tw) begin
        tw = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge mclk); while (!s_axi_bvalid);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge mclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  initial begin
    logic [31:0] d, hd;
    logic [1:0] r;
    logic [63:0] hw;
    logic [3:0] z;
    int kd, kw, n;
    // jumper missing, freeze strapped: must still act as off
    rst(0, 0, 1);
    // reset values of mode, interval and factor words
    for (int i = 0; i < 3; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, i);
      chk(r, 2'b00);
    end
    rd(8'h0c, d, r);
    chk(d[13:0], {1'b0, station_addr_switch, 6'h23});
    rd(8'h10, d, r);
    chk(r, 2'b10);
    wr(8'h10, 32'h0000_0005);
    chk(bresp_seen, 2'b10);
    wr(8'h04, 0);
    chk(bresp_seen, 2'b00);
    rd(8'h04, d, r);
    chk(d, 1);
    // count updates while the master streams fresh data
    run <= 1;
    wr(8'h04, 3);
    load <= 1;
    kd = 0;
    kw = 0;
    hd = dout;
    hw = wout;
    for (int k = 0; k < 300; k++) begin
      dimg <= $random(seed);
      wimg <= {$random(seed), $random(seed)};
      din_field <= $random(seed);
      @(posedge mclk);
      kd += dout !== hd;
      kw += wout !== hw;
      hd = dout;
      hw = wout;
    end
    chk(kd >= 9 && kd <= 10, 1);
    chk(kw >= 4 && kw <= 5, 1);
    load <= 0;
    wr(8'h04, 1);
    cyc(40);
    st(0);
    chk(dout, dout_cmd);
    chk(din_report, din_field);
    chk(wout, wout_cmd);
    // each fault condition with the jumper absent
    for (int i = 0; i < 7; i++) begin
      hw = wout;
      z = $random(seed);
      word_zero_select <= z;
      run <= i != 0;
      halt <= i == 1;
      slot_wrong <= i == 2 ? 4'h1 : 4'h0;
      slot_match <= i == 2 || i == 3 ? 4'he : 4'hf;
      diag_fail <= i > 3;
      diag_kind <= diag_kind_t'(2'(i));
      cyc(4);
      st(0);
      chk(dout, 0);
      for (int j = 0; j < NS; j++)
        if (z[j])
          hw[16*j+:16] = 0;
      chk(wout, hw);
      if (i == 1)
        chk(din_report, 0);
    end
    // tolerance on: only the mismatching slot is skipped
    diag_fail <= 0;
    slot_match <= 4'he;
    slot_wrong <= 4'h1;
    wr(8'h00, 1);
    load <= 1;
    dimg <= $random(seed);
    cyc(1);
    load <= 0;
    cyc(40);
    st(1);
    chk(dout, {dout_cmd[NS*8-1:8], 8'h00});
    display_select_switch <= 1;
    cyc(4);
    st(1);
    // address display, freeze jumper fitted
    slot_match <= 4'hf;
    slot_wrong <= 4'h0;
    rst(1, 1, 1);
    n = 0;
    for (int k = 0; k < 3; k++) begin
      while (disp_char === 5'h1f && n++ < 300) cyc(1);
      chk(disp_char, station_addr_switch / (k == 0 ? 100 : k == 1 ? 10 : 1)
          % 10);
      while (disp_char !== 5'h1f && n++ < 300) cyc(1);
      kd = 0;
      while (disp_char === 5'h1f && kd++ < 300) cyc(1);
      chk(kd, k == 2 ? 40 : 10);
    end
    hd = dout;
    hw = wout;
    word_zero_select <= 4'hf;
    run <= 0;
    cyc(4);
    chk(dout, hd);
    chk(wout, hw);
    end_of_test();
  end
endmodule
